//--- core/fifo_port_control.sv
// Port control of a 36-bit dual-clock FIFO: write, read, flags, offsets.
// Assumes the write and read clocks arrive as pins that are oversampled
// by sys_clk, which must run well above either of them.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module fifo_port_control (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic masterResetN,
  input wire logic wrClkIn,
  input wire logic rdClkIn,
  input wire logic writeEnN,
  input wire logic readEnN,
  input wire logic outEnN,
  input wire logic [35:0] dataIn,
  input wire logic fallThroughSerialIn,
  input wire logic serialLoadEnN,
  input wire logic offsetAccessN,
  input wire logic defaultOffsetSel0,
  input wire logic defaultOffsetSel1,
  input wire logic busMatchSelect,
  input wire logic inputWidthSelect,
  input wire logic outputWidthSelect,
  input wire logic byteOrderSelectN,
  input wire logic flagTimingSelect,
  input wire logic parityLayoutSelect,
  input wire logic asyncReadSelectN,
  input wire logic asyncWriteSelectN,
  output logic fullFlagN,
  output logic emptyFlagN,
  output logic almostEmptyFlagN,
  output logic almostFullFlagN,
  output logic halfFullFlagN,
  output logic [35:0] dataOut,
  output logic dataOutEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: every pin passes two flip-flops.

  localparam int PINS = 55;
  logic [PINS-1:0] pinMeta;
  logic [PINS-1:0] pinSync;
  logic wrClkPrev, rdClkPrev;

  always_ff @(posedge sys_clk) begin
    pinMeta <= {masterResetN, wrClkIn, rdClkIn, writeEnN, readEnN, outEnN,
      fallThroughSerialIn, serialLoadEnN, offsetAccessN, defaultOffsetSel0,
      defaultOffsetSel1, busMatchSelect, inputWidthSelect, outputWidthSelect,
      byteOrderSelectN, flagTimingSelect, parityLayoutSelect,
      asyncReadSelectN, asyncWriteSelectN, dataIn};
    pinSync <= pinMeta;
    wrClkPrev <= pinSync[53];
    rdClkPrev <= pinSync[52];
  end

  logic master_reset_n, weS, reS, oeS, siS, senS, ldS;
  logic [35:0] dS;
  assign master_reset_n = pinSync[54];
  assign weS = pinSync[51];
  assign reS = pinSync[50];
  assign oeS = pinSync[49];
  assign siS = pinSync[48];
  assign senS = pinSync[47];
  assign ldS = pinSync[46];
  assign dS = pinSync[35:0];

  logic wrEvt, rdEvt, mrActive;
  assign wrEvt = pinSync[53] & ~wrClkPrev;
  assign rdEvt = pinSync[52] & ~rdClkPrev;
  assign mrActive = ~rstn | ~master_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration straps.

  logic cfgFwft, cfgSerial, cfgBigEnd, cfgSyncFlags, cfgParity;
  logic cfgAsyncRd, cfgAsyncWr;
  logic [2:0] cfgDefSel;
  fifo_ctl_pkg::bus_mode_t cfgBus;

  always_ff @(posedge sys_clk) begin
    if (mrActive) begin
      cfgFwft <= pinSync[48] & pinSync[37];
      cfgSerial <= pinSync[46];
      cfgDefSel <= {pinSync[46], pinSync[44], pinSync[45]};
      cfgBigEnd <= ~pinSync[40];
      cfgSyncFlags <= pinSync[39];
      cfgParity <= pinSync[38];
      cfgAsyncRd <= ~pinSync[37];
      cfgAsyncWr <= ~pinSync[36];
      if (!pinSync[43]) begin
        cfgBus <= fifo_ctl_pkg::BUS_36_36;
      end else begin
        case ({pinSync[42], pinSync[41]})
          2'b00: cfgBus <= fifo_ctl_pkg::BUS_36_18;
          2'b01: cfgBus <= fifo_ctl_pkg::BUS_36_9;
          2'b10: cfgBus <= fifo_ctl_pkg::BUS_18_36;
          default: cfgBus <= fifo_ctl_pkg::BUS_9_36;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers.

  logic [35:0] mem [0:1023];
  logic [10:0] wrPtr, rdPtr, rdPtrW1, rdPtrW2, wrPtrR1, wrPtrR2;
  logic flush, wrEvtD, rdEvtD;
  logic ldLow, fullNow, memEmpty, emptyAll, unitIn, unitOut, fifoWrite;
  logic [1:0] inPhase, outPhase, inLast, outLast;
  logic [35:0] packWord, nextPack;
  fifo_ctl_pkg::out_state_t outState;
  logic [10:0] level, levelR, levelW, outCnt;
  logic [9:0] emptyOff, fullOff;

  assign ldLow = ~ldS;
  assign inLast = (cfgBus == fifo_ctl_pkg::BUS_9_36) ? 2'h3 :
    (cfgBus == fifo_ctl_pkg::BUS_18_36) ? 2'h1 : 2'h0;
  assign outLast = (cfgBus == fifo_ctl_pkg::BUS_36_9) ? 2'h3 :
    (cfgBus == fifo_ctl_pkg::BUS_36_18) ? 2'h1 : 2'h0;
  assign fullNow = cfgAsyncWr ? (wrPtr - rdPtr) == fifo_ctl_pkg::DEPTH_CNT :
    (wrPtr - rdPtrW2) == fifo_ctl_pkg::DEPTH_CNT;
  assign memEmpty = cfgAsyncRd ? rdPtr == wrPtr : rdPtr == wrPtrR2;
  assign emptyAll = memEmpty && outPhase == 2'h0;
  assign unitIn = wrEvt & ~weS & ~ldLow & ~fullNow;
  assign fifoWrite = unitIn && inPhase == inLast;
  assign outCnt = {10'h000,
    cfgFwft && outState == fifo_ctl_pkg::OUT_VALID};
  assign level = wrPtr - rdPtr + outCnt;
  assign levelR = wrPtrR2 - rdPtr + outCnt;
  assign levelW = wrPtr - rdPtrW2;

  // Narrow input units are packed into a long word; big-endian puts the
  // first unit on top, little-endian at the bottom.
  always_comb begin
    nextPack = dS;
    case (cfgBus)
      fifo_ctl_pkg::BUS_18_36:
        nextPack = cfgBigEnd ? {packWord[17:0], dS[17:0]} :
          {dS[17:0], packWord[35:18]};
      fifo_ctl_pkg::BUS_9_36:
        nextPack = cfgBigEnd ? {packWord[26:0], dS[8:0]} :
          {dS[8:0], packWord[35:9]};
      default: nextPack = dS;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (mrActive || flush) begin
      wrPtr <= 11'h000;
      inPhase <= 2'h0;
      packWord <= 36'h000000000;
    end else if (unitIn) begin
      packWord <= nextPack;
      inPhase <= (inPhase == inLast) ? 2'h0 : inPhase + 2'h1;
      if (inPhase == inLast) begin
        wrPtr <= wrPtr + 11'h001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (fifoWrite) begin
      mem[wrPtr[9:0]] <= nextPack;
    end
  end

  // Each side sees the other's pointer two of its own edges late.
  always_ff @(posedge sys_clk) begin
    wrEvtD <= wrEvt;
    rdEvtD <= rdEvt;
    if (mrActive || flush) begin
      rdPtrW1 <= 11'h000;
      rdPtrW2 <= 11'h000;
      wrPtrR1 <= 11'h000;
      wrPtrR2 <= 11'h000;
    end else begin
      if (wrEvt) begin
        rdPtrW1 <= rdPtr;
        rdPtrW2 <= rdPtrW1;
      end
      if (rdEvt) begin
        wrPtrR1 <= wrPtr;
        wrPtrR2 <= wrPtrR1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side and output register.

  logic rdReq, takeSlot, canFetch, offRdSel, offWrSel;
  logic [35:0] holdWord, fetchWord;
  assign rdReq = rdEvt & ~reS;
  assign takeSlot = cfgFwft ? (rdReq || outState != fifo_ctl_pkg::OUT_VALID)
    : rdReq;
  assign canFetch = !emptyAll;
  assign unitOut = rdEvt & ~ldLow & takeSlot & canFetch;
  assign fetchWord = mem[rdPtr[9:0]];

  function automatic logic [35:0] unitOf(input logic [35:0] w,
      input logic [1:0] ph, input fifo_ctl_pkg::bus_mode_t bus,
      input logic big);
    logic [1:0] k;
    k = big ? ph : 2'h3 - ph;
    case (bus)
      fifo_ctl_pkg::BUS_36_18:
        unitOf = (big ^ ph[0]) ? {18'h00000, w[35:18]} :
          {18'h00000, w[17:0]};
      fifo_ctl_pkg::BUS_36_9: begin
        case (k)
          2'h0: unitOf = {27'h0000000, w[35:27]};
          2'h1: unitOf = {27'h0000000, w[26:18]};
          2'h2: unitOf = {27'h0000000, w[17:9]};
          default: unitOf = {27'h0000000, w[8:0]};
        endcase
      end
      default: unitOf = w;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (mrActive || flush) begin
      rdPtr <= 11'h000;
      outPhase <= 2'h0;
      holdWord <= 36'h000000000;
      dataOut <= 36'h000000000;
      outState <= fifo_ctl_pkg::OUT_EMPTY;
    end else if (rdEvt && ldLow && rdReq) begin
      dataOut <= offRdSel ? {26'h0000000, fullOff} :
        {26'h0000000, emptyOff};
    end else if (unitOut) begin
      outState <= fifo_ctl_pkg::OUT_VALID;
      outPhase <= (outPhase == outLast) ? 2'h0 : outPhase + 2'h1;
      if (outPhase == 2'h0) begin
        holdWord <= fetchWord;
        rdPtr <= rdPtr + 11'h001;
        dataOut <= unitOf(fetchWord, 2'h0, cfgBus, cfgBigEnd);
      end else begin
        dataOut <= unitOf(holdWord, outPhase, cfgBus, cfgBigEnd);
      end
    end else if (cfgFwft && rdReq && !ldLow) begin
      outState <= fifo_ctl_pkg::OUT_EMPTY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dataOutEn <= 1'b0;
    end else begin
      dataOutEn <= ~oeS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset registers.

  logic [9:0] parOff;
  assign parOff = cfgParity ? {dS[10:9], dS[7:0]} : dS[9:0];

  always_ff @(posedge sys_clk) begin
    if (mrActive) begin
      emptyOff <= fifo_ctl_pkg::DEF_OFFSET[cfgDefSel];
      fullOff <= fifo_ctl_pkg::DEF_OFFSET[cfgDefSel];
      offWrSel <= 1'b0;
      offRdSel <= 1'b0;
    end else if (!ldLow) begin
      offWrSel <= 1'b0;
      offRdSel <= 1'b0;
    end else begin
      if (wrEvt && cfgSerial && !senS) begin
        {fullOff, emptyOff} <= {fullOff[8:0], emptyOff, siS};
      end else if (wrEvt && !cfgSerial && !weS) begin
        offWrSel <= ~offWrSel;
        if (offWrSel) begin
          fullOff <= parOff;
        end else begin
          emptyOff <= parOff;
        end
      end
      if (rdReq) begin
        offRdSel <= ~offRdSel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, evaluated one system cycle after their clock edge.

  always_ff @(posedge sys_clk) begin
    if (mrActive || flush) begin
      fullFlagN <= ~cfgFwft;
      emptyFlagN <= 1'b0;
      halfFullFlagN <= 1'b1;
      almostEmptyFlagN <= 1'b0;
      almostFullFlagN <= 1'b1;
    end else begin
      if (wrEvtD || (cfgAsyncWr && rdEvtD)) begin
        fullFlagN <= cfgFwft ? fullNow : ~fullNow;
      end
      if (cfgFwft) begin
        emptyFlagN <= outState != fifo_ctl_pkg::OUT_VALID;
      end else if (rdEvtD || (cfgAsyncRd && wrEvtD)) begin
        emptyFlagN <= ~emptyAll;
      end
      if (wrEvtD && level > fifo_ctl_pkg::HALF_CNT) begin
        halfFullFlagN <= 1'b0;
      end else if (rdEvtD && level <= fifo_ctl_pkg::HALF_CNT) begin
        halfFullFlagN <= 1'b1;
      end
      if (cfgSyncFlags) begin
        if (rdEvtD) begin
          almostEmptyFlagN <= levelR > {1'b0, emptyOff};
        end
        if (wrEvtD) begin
          almostFullFlagN <= levelW < fifo_ctl_pkg::DEPTH_CNT - fullOff;
        end
      end else begin
        if (rdEvtD && level <= {1'b0, emptyOff}) begin
          almostEmptyFlagN <= 1'b0;
        end else if (wrEvtD && level > {1'b0, emptyOff}) begin
          almostEmptyFlagN <= 1'b1;
        end
        if (wrEvtD && level >= fifo_ctl_pkg::DEPTH_CNT - fullOff) begin
          almostFullFlagN <= 1'b0;
        end else if (rdEvtD && level < fifo_ctl_pkg::DEPTH_CNT - fullOff)
        begin
          almostFullFlagN <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY.

  logic dataPhWr;
  logic [7:0] dataPhAddr;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      dataPhWr <= 1'b0;
      dataPhAddr <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dataPhWr <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        dataPhWr <= hwrite && hsize == fifo_ctl_pkg::HSIZE_WORD;
        dataPhAddr <= haddr[7:0];
        case (haddr[7:0])
          fifo_ctl_pkg::REG_STATUS: begin
            hrdata <= 32'h00000000;
            hrdata[fifo_ctl_pkg::ST_FULL] <= fullNow;
            hrdata[fifo_ctl_pkg::ST_EMPTY] <= emptyAll;
            hrdata[fifo_ctl_pkg::ST_AEMPTY] <= ~almostEmptyFlagN;
            hrdata[fifo_ctl_pkg::ST_AFULL] <= ~almostFullFlagN;
            hrdata[fifo_ctl_pkg::ST_HALF] <= ~halfFullFlagN;
            hrdata[fifo_ctl_pkg::ST_FALL_THROUGH_MODE] <= cfgFwft;
            hrdata[fifo_ctl_pkg::ST_SERIAL] <= cfgSerial;
            hrdata[fifo_ctl_pkg::ST_BUS +: 5] <= cfgBus;
          end
          fifo_ctl_pkg::REG_LEVEL: hrdata <= {21'h000000, level};
          fifo_ctl_pkg::REG_OFFSETS:
            hrdata <= {6'h00, fullOff, 6'h00, emptyOff};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Flush clears data like a partial reset and keeps the offsets.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flush <= 1'b0;
    end else begin
      flush <= dataPhWr && dataPhAddr == fifo_ctl_pkg::REG_CTRL &&
        hwdata[fifo_ctl_pkg::CTRL_FLUSH];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (mrActive);

  a_write_full_blocked: assert property (
    wrEvt && fullNow && !flush |=> $stable(wrPtr))
    else $error("Write pointer moved while full.");
  a_wen_high_holds: assert property (
    wrEvt && weS && !flush |=> $stable(wrPtr) && $stable(inPhase))
    else $error("Write taken with enable high.");
  a_full_lags_two: assert property (
    wrEvt && !flush |=> rdPtrW2 == $past(rdPtrW1) &&
      rdPtrW1 == $past(rdPtr))
    else $error("Read pointer view not two write edges late.");
  a_half_rise_read: assert property (
    $rose(halfFullFlagN) |-> $past(rdEvtD) || $past(flush))
    else $error("Half-full flag raised without read edge.");
  a_half_fall_write: assert property (
    $fell(halfFullFlagN) |-> $past(wrEvtD))
    else $error("Half-full flag lowered without write edge.");
  a_ren_high_hold: assert property (
    !cfgFwft && rdEvt && reS && !flush |=> $stable(dataOut))
    else $error("Output register changed with read enable high.");
  a_empty_read_ignored: assert property (
    !cfgFwft && rdEvt && emptyAll && !flush |=> $stable(rdPtr))
    else $error("Read taken while empty.");
  a_true_read_ready: assert property (
    cfgFwft && rdReq && !ldLow && emptyAll && !flush |=> ##1 emptyFlagN)
    else $error("Output ready not raised after last word.");
  a_oe_follows: assert property (
    ##1 1'b1 |-> dataOutEn == !$past(oeS))
    else $error("Output enable not followed.");
  a_straps_held: assert property (
    $past(!mrActive) |-> $stable(cfgFwft) && $stable(cfgBus))
    else $error("Strap configuration changed outside reset.");
  a_serial_hold: assert property (
    cfgSerial && (senS || !ldLow) |=> $stable(emptyOff))
    else $error("Offsets changed with serial enable high.");

  c_full: cover property (fullNow && wrEvt);
  c_fall_through: cover property (cfgFwft && $fell(emptyFlagN));
  c_serial_load: cover property (wrEvt && cfgSerial && !senS && ldLow);
  c_narrow_out: cover property (unitOut && outPhase == 2'h1);

endmodule // fifo_port_control

`default_nettype wire

//--- core/fifo_ctl_pkg.sv
// Constants, field layouts and types of the dual-clock FIFO port control.
// Assumes a single system clock; every pin is synchronised inside the port control.
package fifo_ctl_pkg;

  // Storage geometry, counted in long (36-bit) words.
  localparam int DEPTH_LOG = 10;
  localparam int PTR_W = 11;
  localparam int OFF_W = 10;
  localparam logic [10:0] DEPTH_CNT = 11'h400;
  localparam logic [10:0] HALF_CNT = 11'h200;

  // Default almost-empty/almost-full offsets, chosen by three strap bits.
  localparam logic [9:0] DEF_OFFSET [0:7] = '{
    10'h007, 10'h00f, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff
  };

  // Bus width combinations, input width then output width.
  typedef enum logic [4:0] {
    BUS_36_36 = 5'b00001,
    BUS_36_18 = 5'b00010,
    BUS_36_9  = 5'b00100,
    BUS_18_36 = 5'b01000,
    BUS_9_36  = 5'b10000
  } bus_mode_t;

  // Read side presentation state in fall-through mode.
  typedef enum logic [1:0] {
    OUT_EMPTY = 2'b01,
    OUT_VALID = 2'b10
  } out_state_t;

  // Register map, byte addresses on the AHB-Lite slave.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEVEL = 8'h08;
  localparam logic [7:0] REG_OFFSETS = 8'h0c;

  // Field positions.
  localparam int CTRL_FLUSH = 0;
  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_AEMPTY = 2;
  localparam int ST_AFULL = 3;
  localparam int ST_HALF = 4;
  localparam int ST_FALL_THROUGH_MODE = 5;
  localparam int ST_SERIAL = 6;
  localparam int ST_BUS = 8;
  localparam int OFFS_FULL = 16;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

//--- verification/pin_partner.sv
// Writer and reader logic that drive the FIFO pin clocks and enables.
// Assumes sys_clk runs at least twelve times faster than either pin clock.
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic sys_clk,
  output logic wrClk,
  output logic rdClk,
  output logic writeEnN,
  output logic readEnN,
  output logic [35:0] dataIn
);
  logic strobeMode;
  initial begin
    strobeMode = 1'b0;
    wrClk = 1'b0;
    rdClk = 1'b0;
    writeEnN = 1'b1;
    readEnN = 1'b1;
    dataIn = 36'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Enable and data settle before the rise and hold well after the fall.
  // Released data shows its inverse so that stale words never look fresh.
  // The pin clocks stand still between cycles.
  task automatic wr_cycle(input logic en, input logic [35:0] d);
    @(posedge sys_clk);
    writeEnN <= ~en;
    dataIn <= d;
    repeat (3) @(posedge sys_clk);
    wrClk <= 1'b1;
    repeat (6) @(posedge sys_clk);
    wrClk <= 1'b0;
    repeat (6) @(posedge sys_clk);
    writeEnN <= ~strobeMode;
    dataIn <= ~d;
  endtask
  task automatic rd_cycle(input logic en);
    @(posedge sys_clk);
    readEnN <= ~en;
    repeat (3) @(posedge sys_clk);
    rdClk <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rdClk <= 1'b0;
    repeat (6) @(posedge sys_clk);
    readEnN <= ~strobeMode;
  endtask
  // Strobe-mode ports keep both enables tied low between cycles.
  task automatic tie_enables(input logic tie);
    @(posedge sys_clk);
    strobeMode = tie;
    writeEnN <= ~tie;
    readEnN <= ~tie;
  endtask
endmodule // pin_partner
`default_nettype wire

//--- verification/dual_clock_fifo_port_control_bench.sv
// Self-checking bench of the FIFO port control in standard x36 mode,
// then in strobe mode with a x36 to x18 bus.
// Assumes the pin partner model and the AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
module dual_clock_fifo_port_control_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic masterResetN = 1'b0;
  logic outEnN = 1'b0;
  logic serIn = 1'b0;
  logic serEnN = 1'b1;
  logic offAccN = 1'b1;
  // Straps: async write, async read, parity, flag timing, byte order,
  // output width, input width, bus match, default select 1 and 0.
  logic [9:0] strap = 10'h300;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic wrClk, rdClk, writeEnN, readEnN, hready, hresp;
  wire logic fullN, emptyN, aeN, afN, halfN, dataOutEn;
  wire logic [35:0] dataIn, dataOut;
  wire logic [31:0] hrdata;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  always #2 sys_clk = ~sys_clk;
  pin_partner i_pin_partner (.sys_clk(sys_clk), .wrClk(wrClk),
    .rdClk(rdClk), .writeEnN(writeEnN), .readEnN(readEnN), .dataIn(dataIn));
  fifo_port_control i_fifo_port_control (.sys_clk(sys_clk), .rstn(rstn),
    .masterResetN(masterResetN), .wrClkIn(wrClk), .rdClkIn(rdClk),
    .writeEnN(writeEnN), .readEnN(readEnN), .outEnN(outEnN),
    .dataIn(dataIn), .fallThroughSerialIn(serIn), .serialLoadEnN(serEnN),
    .offsetAccessN(offAccN), .defaultOffsetSel0(strap[0]),
    .defaultOffsetSel1(strap[1]), .busMatchSelect(strap[2]),
    .inputWidthSelect(strap[3]), .outputWidthSelect(strap[4]),
    .byteOrderSelectN(strap[5]), .flagTimingSelect(strap[6]),
    .parityLayoutSelect(strap[7]), .asyncReadSelectN(strap[8]),
    .asyncWriteSelectN(strap[9]), .fullFlagN(fullN), .emptyFlagN(emptyN),
    .almostEmptyFlagN(aeN), .almostFullFlagN(afN), .halfFullFlagN(halfN),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp,
    input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One single-word AHB-Lite transfer; read data taken at the data edge.
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= fifo_ctl_pkg::HSIZE_WORD;
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  function automatic logic [35:0] wd(int i);
    return 36'h5a5a00000 ^ 36'(i);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    ahb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0, rd);
    chk(36'(rd[12:8]), 36'h1, "bus mode");
    chk(36'(rd[5]), 36'h0, "fall-through");
    chk(36'(rd[6]), 36'h1, "serial method");
    chk(36'(emptyN), 36'h0, "empty after reset");
    chk(36'(fullN), 36'h1, "not full after reset");
    ahb(1'b0, fifo_ctl_pkg::REG_OFFSETS, 32'h0, rd);
    chk(36'(rd), 36'h007f007f, "default offsets");
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk(36'(rd), 36'h0, "unmapped read");
    chk(36'(hresp), 36'h0, "okay response");
    $display("test reset done");
  endtask
  task automatic t_single();
    i_pin_partner.wr_cycle(1'b0, wd(9));
    i_pin_partner.wr_cycle(1'b1, wd(1));
    chk(36'(emptyN), 36'h0, "empty before read edges");
    i_pin_partner.rd_cycle(1'b0);
    i_pin_partner.rd_cycle(1'b0);
    chk(36'(emptyN), 36'h1, "empty released");
    chk(dataOut, 36'h0, "held output");
    i_pin_partner.rd_cycle(1'b1);
    chk(dataOut, wd(1), "read word");
    chk(36'(emptyN), 36'h0, "empty after last");
    i_pin_partner.rd_cycle(1'b1);
    chk(dataOut, wd(1), "read while empty");
    outEnN <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk(36'(dataOutEn), 36'h0, "bus floated");
    outEnN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(36'(dataOutEn), 36'h1, "bus driven");
    $display("test single done");
  endtask
  task automatic t_serial();
    logic [19:0] v;
    v = 20'ha5c3b;
    offAccN <= 1'b0;
    serEnN <= 1'b0;
    for (int b = 19; b >= 0; b--) begin
      serIn <= v[b];
      i_pin_partner.wr_cycle(1'b0, 36'h0);
    end
    serEnN <= 1'b1;
    serIn <= 1'b1;
    i_pin_partner.wr_cycle(1'b0, 36'h0);
    offAccN <= 1'b1;
    ahb(1'b0, fifo_ctl_pkg::REG_OFFSETS, 32'h0, rd);
    chk(36'(rd), {10'h0, v[19:10], 6'h0, v[9:0]}, "serial offsets");
    $display("test serial done");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 1024; i++) i_pin_partner.wr_cycle(1'b1, wd(i));
    chk(36'(fullN), 36'h0, "full flag");
    chk(36'(halfN), 36'h0, "half full");
    chk(36'(afN), 36'h0, "almost full set by writes");
    chk(36'(aeN), 36'h1, "almost empty cleared by writes");
    i_pin_partner.wr_cycle(1'b1, wd(2000));
    ahb(1'b0, fifo_ctl_pkg::REG_LEVEL, 32'h0, rd);
    chk(36'(rd[10:0]), 36'h400, "write while full");
    i_pin_partner.rd_cycle(1'b0);
    i_pin_partner.rd_cycle(1'b0);
    i_pin_partner.rd_cycle(1'b1);
    chk(dataOut, wd(0), "first word");
    chk(36'(fullN), 36'h0, "full before write edges");
    i_pin_partner.wr_cycle(1'b0, 36'h0);
    i_pin_partner.wr_cycle(1'b0, 36'h0);
    chk(36'(fullN), 36'h1, "full released");
    for (int i = 1; i < 1024; i++) begin
      i_pin_partner.rd_cycle(1'b1);
      chk(dataOut, wd(i), "word order");
    end
    chk(36'(halfN), 36'h1, "half full cleared by reads");
    chk(36'(emptyN), 36'h0, "drained");
    chk(36'(aeN), 36'h0, "almost empty set by reads");
    chk(36'(afN), 36'h1, "almost full cleared by reads");
    i_pin_partner.wr_cycle(1'b1, wd(7));
    ahb(1'b1, fifo_ctl_pkg::REG_CTRL, 32'h1, rd);
    ahb(1'b0, fifo_ctl_pkg::REG_LEVEL, 32'h0, rd);
    chk(36'(rd[10:0]), 36'h0, "flush");
    $display("test fill done");
  endtask
  // Second master reset: strobe ports, x36 to x18 big-endian, sync flags.
  task automatic t_async();
    masterResetN <= 1'b0;
    serIn <= 1'b1;
    strap <= 10'h0c7;
    i_pin_partner.tie_enables(1'b1);
    repeat (6) @(posedge sys_clk);
    masterResetN <= 1'b1;
    serIn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    ahb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0, rd);
    chk(36'(rd[12:8]), 36'h2, "narrow bus mode");
    chk(36'(rd[5]), 36'h0, "strobe read forbids fall-through");
    ahb(1'b0, fifo_ctl_pkg::REG_OFFSETS, 32'h0, rd);
    chk(36'(rd), 36'h03ff03ff, "second default offsets");
    i_pin_partner.wr_cycle(1'b1, {18'h2a5a5, 18'h1c3c3});
    chk(36'(emptyN), 36'h1, "strobe write clears empty");
    chk(36'(afN), 36'h0, "almost full on write edge");
    i_pin_partner.rd_cycle(1'b1);
    chk(dataOut, 36'h00002a5a5, "first half out");
    i_pin_partner.rd_cycle(1'b1);
    chk(dataOut, 36'h00001c3c3, "second half out");
    chk(36'(emptyN), 36'h0, "empty after strobe reads");
    chk(36'(afN), 36'h0, "reads leave almost full");
    $display("test async done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    masterResetN <= 1'b1;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_single();
    t_serial();
    t_fill();
    t_async();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end
endmodule // dual_clock_fifo_port_control_bench
`default_nettype wire
